// [verilog/wdr_watchdog_reset_timer.sv]
`timescale 1ns/1ns
module wdr_watchdog_reset_timer (
    input wire logic clk, // System clock, 100 MHz.
    input wire logic resetn, // Synchronous chip reset, active low.
    input wire wdr_pkg::wdr_cmd_s cmd, // One-cycle instruction pulses from the CPU.
    input wire wdr_pkg::wdr_cfg_s cfg, // Prescaler and reload write.
    output logic hw_reset_req, // Internal hardware reset request, level.
    output logic reset_output_pin, // Reset output pin, low means reset.
    output logic wdt_running, // Counter is enabled.
    output logic init_done, // End of initialization has run.
    output logic [wdr_pkg::WDR_CNT_W-1:0] wdt_count // Current counter value.
);
    import wdr_pkg::*;

    // ----------------------------------------------------------------
    // Configuration holding registers
    // ----------------------------------------------------------------
    logic [1:0] presc_sel_q, presc_sel_d;
    logic [WDR_REL_W-1:0] reload_q, reload_d;

    always_comb begin
        presc_sel_d = presc_sel_q;
        reload_d = reload_q;
        if (cfg.wr) begin
            presc_sel_d = cfg.presc_sel;
            reload_d = cfg.wdt_reload_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            presc_sel_q <= WDR_SEL_RESET;
            reload_q <= WDR_RELOAD_RESET;
        end else begin
            presc_sel_q <= presc_sel_d;
            reload_q <= reload_d;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    wdr_state_e state_q, state_d;
    logic tick;
    logic presc_clr;

    // Service restarts the division so every interval has the same length.
    assign presc_clr = (state_q != WDR_ST_RUN) || cmd.service || cfg.wr;

    wdr_prescaler #(
        .PRE_W(WDR_PRE_W)
    ) u_presc (
        .clk(clk),
        .resetn(resetn),
        .clr(presc_clr),
        .sel(presc_sel_q),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Counter and control
    // ----------------------------------------------------------------
    logic [WDR_CNT_W-1:0] cnt_q, cnt_d;
    logic end_of_init_instruction_q, end_of_init_instruction_d;
    logic pin_q, pin_d;
    logic overflow;

    // A service in the same cycle as the final tick still rescues the system.
    assign overflow = (state_q == WDR_ST_RUN) && tick && !cmd.service && (cnt_q == WDR_CNT_MAX);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        end_of_init_instruction_d = end_of_init_instruction_q;
        pin_d = pin_q;
        case (state_q)
            WDR_ST_RUN: begin
                if (cmd.disable_req && !end_of_init_instruction_q) begin
                    state_d = WDR_ST_OFF;
                end else if (cmd.service) begin
                    cnt_d = {reload_q, 8'h00};
                end else if (overflow) begin
                    state_d = WDR_ST_TRIP;
                    pin_d = 1'b0;
                end else if (tick) begin
                    cnt_d = cnt_q + WDR_CNT_W'(1);
                end
            end
            WDR_ST_OFF: begin
                if (cmd.service) begin
                    cnt_d = {reload_q, 8'h00};
                end
            end
            WDR_ST_TRIP: begin
                pin_d = 1'b0;
            end
            default: begin
                state_d = WDR_ST_RUN;
            end
        endcase
        if (cmd.end_of_init_instruction && state_d != WDR_ST_TRIP) begin
            end_of_init_instruction_d = 1'b1;
            pin_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= WDR_ST_RUN;
            cnt_q <= WDR_CNT_RESET;
            end_of_init_instruction_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            end_of_init_instruction_q <= end_of_init_instruction_d;
            pin_q <= pin_d;
        end
    end

    assign hw_reset_req = (state_q == WDR_ST_TRIP);
    assign reset_output_pin = pin_q;
    assign wdt_running = (state_q == WDR_ST_RUN);
    assign init_done = end_of_init_instruction_q;
    assign wdt_count = cnt_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_last_tick;
        state_q == WDR_ST_RUN && tick && !cmd.service && cnt_q == WDR_CNT_MAX;
    endsequence

    sequence s_tripped;
        hw_reset_req && !reset_output_pin;
    endsequence

    a_run_after_reset: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |=> wdt_running && cnt_q == 16'h0000)
        else $error("Watchdog not running after reset.");

    a_late_disable: assert property (cmd.disable_req && end_of_init_instruction_q && state_q == WDR_ST_RUN
        |=> state_q != WDR_ST_OFF)
        else $error("Disable accepted after end of initialization.");

    a_overflow_trip: assert property (s_last_tick |=> s_tripped [*2])
        else $error("Overflow did not trip reset.");

    a_div2_rate: assert property (presc_sel_q == WDR_SEL_DIV2 && !presc_clr && tick
        && !cfg.wr ##1 !presc_clr |-> !tick ##1 tick)
        else $error("Divide by two tick rate wrong.");

    a_count_step: assert property (state_q == WDR_ST_RUN && tick && !cmd.service
        && !cmd.disable_req && cnt_q != WDR_CNT_MAX |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Counter did not step on tick.");

    a_service_load: assert property (state_q == WDR_ST_RUN && cmd.service && !cmd.disable_req
        |=> cnt_q == {$past(reload_q), 8'h00})
        else $error("Service did not load reload value.");

    a_reset_defaults: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |=> presc_sel_q == 2'h0 && reload_q == 8'h00)
        else $error("Reset defaults wrong.");

    a_end_of_init_instruction_pin: assert property (cmd.end_of_init_instruction && state_q == WDR_ST_RUN
        && !tick |=> reset_output_pin && init_done)
        else $error("End of init did not release pin.");
endmodule

// [verilog/wdr_pkg.sv]
package wdr_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int WDR_CNT_W = 16;
    localparam int WDR_REL_W = 8;
    localparam int WDR_PRE_W = 8;
    localparam logic [1:0] WDR_SEL_DIV2 = 2'h0;
    localparam logic [1:0] WDR_SEL_DIV4 = 2'h1;
    localparam logic [1:0] WDR_SEL_DIV128 = 2'h2;
    localparam logic [1:0] WDR_SEL_DIV256 = 2'h3;
    // Divide by 2 and reload 00h: 65536 * 2 / 100 MHz = 1.31 ms.
    localparam logic [1:0] WDR_SEL_RESET = WDR_SEL_DIV2;
    localparam logic [WDR_REL_W-1:0] WDR_RELOAD_RESET = 8'h00;
    localparam logic [WDR_CNT_W-1:0] WDR_CNT_RESET = 16'h0000;
    localparam logic [WDR_CNT_W-1:0] WDR_CNT_MAX = 16'hFFFF;
    localparam logic [WDR_PRE_W-1:0] WDR_PRE_ZERO = 8'h00;
    localparam logic [WDR_PRE_W-1:0] WDR_PRE_ONE = 8'h01;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WDR_ST_RUN = 2'h0,
        WDR_ST_TRIP = 2'h1,
        WDR_ST_OFF = 2'h2
    } wdr_state_e;

    typedef struct packed {
        logic service;
        logic disable_req;
        logic end_of_init_instruction;
    } wdr_cmd_s;

    typedef struct packed {
        logic wr;
        logic [1:0] presc_sel;
        logic [WDR_REL_W-1:0] wdt_reload_value;
    } wdr_cfg_s;

    // Last prescaler count of a period for a divide selection.
    function automatic logic [WDR_PRE_W-1:0] wdr_presc_term(input logic [1:0] sel);
        case (sel)
            WDR_SEL_DIV2: wdr_presc_term = 8'h01;
            WDR_SEL_DIV4: wdr_presc_term = 8'h03;
            WDR_SEL_DIV128: wdr_presc_term = 8'h7F;
            default: wdr_presc_term = 8'hFF;
        endcase
    endfunction

endpackage

// [verilog/wdr_prescaler.sv]
`timescale 1ns/1ns
module wdr_prescaler #(
    parameter int PRE_W = 8
) (
    input wire logic clk, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic clr, // Restart the division period.
    input wire logic [1:0] sel, // Divide selection.
    output logic tick // One-cycle pulse per period.
);
    import wdr_pkg::*;

    logic [PRE_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic at_term;

    always_comb begin
        at_term = (cnt_q == PRE_W'(wdr_presc_term(sel)));
        tick_d = !clr && at_term;
        if (clr || at_term) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + PRE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// [testbench/wdr_cpu_model.sv]
`timescale 1ns/1ns
module wdr_cpu_model (
    input wire logic clk, // System clock.
    output wdr_pkg::wdr_cmd_s cmd, // Instruction pulses.
    output wdr_pkg::wdr_cfg_s cfg // Configuration write.
);
    import wdr_pkg::*;

    initial begin
        cmd = '0;
        cfg = '0;
    end

    // Issues one instruction as a one-cycle pulse just after an edge.
    task automatic instr(input logic srv, input logic dis, input logic ein);
        @(posedge clk);
        #1;
        cmd = '{service: srv, disable_req: dis, end_of_init_instruction: ein};
        @(posedge clk);
        #1;
        cmd = '0;
    endtask

    // Writes divider selection and reload byte in one strobe.
    task automatic cfg_write(input logic [1:0] sel, input logic [7:0] rel);
        @(posedge clk);
        #1;
        cfg = '{wr: 1'b1, presc_sel: sel, wdt_reload_value: rel};
        @(posedge clk);
        #1;
        cfg = '0;
    endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import wdr_pkg::*;

    typedef struct {
        logic [1:0] sel;
        logic [7:0] rel;
        int div;
    } wdr_row_s;

    logic clk;
    logic resetn;
    wdr_cmd_s cmd;
    wdr_cfg_s cfg;
    logic hw_reset_req;
    logic reset_output_pin;
    logic wdt_running;
    logic init_done;
    logic [15:0] wdt_count;
    logic [15:0] c;
    int num_errors = 0;
    int cmp_count = 0;
    wdr_row_s rows [4] = '{'{WDR_SEL_DIV2, 8'hFF, 2}, '{WDR_SEL_DIV4, 8'h80, 4},
        '{WDR_SEL_DIV128, 8'hF0, 128}, '{WDR_SEL_DIV256, 8'h00, 256}};

    wdr_watchdog_reset_timer dut (.clk(clk), .resetn(resetn), .cmd(cmd), .cfg(cfg),
        .hw_reset_req(hw_reset_req), .reset_output_pin(reset_output_pin),
        .wdt_running(wdt_running), .init_done(init_done), .wdt_count(wdt_count));
    wdr_cpu_model cpu (.clk(clk), .cmd(cmd), .cfg(cfg));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clk);
        #1;
        resetn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
    endtask

    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    initial begin
        resetn = 1'b0;
        do_reset();
        check(wdt_running, 1'b1);
        check(hw_reset_req, 1'b0);
        check(reset_output_pin, 1'b0);
        check(init_done, 1'b0);
        check(wdt_count, 16'h0000);
        c = wdt_count;
        // The prescaler needs one extra edge before its first tick reaches the counter.
        repeat (17) @(posedge clk);
        #1;
        check(wdt_count, c + 16'h0008);
        $display("test reset done");
        foreach (rows[i]) begin
            cpu.cfg_write(rows[i].sel, rows[i].rel);
            cpu.instr(1'b1, 1'b0, 1'b0);
            check(wdt_count, {rows[i].rel, 8'h00});
            c = wdt_count;
            repeat (8 * rows[i].div + 1) @(posedge clk);
            #1;
            check(wdt_count, c + 16'h0008);
        end
        $display("test table done");
        cpu.cfg_write(WDR_SEL_DIV2, 8'hFF);
        cpu.instr(1'b1, 1'b0, 1'b0);
        repeat (400) @(posedge clk);
        cpu.instr(1'b1, 1'b0, 1'b0);
        repeat (300) @(posedge clk);
        check(hw_reset_req, 1'b0);
        for (int k = 0; k < 300 && hw_reset_req !== 1'b1; k++) @(posedge clk);
        #1;
        check(hw_reset_req, 1'b1);
        check(reset_output_pin, 1'b0);
        check(wdt_running, 1'b0);
        $display("test overflow done");
        do_reset();
        cpu.instr(1'b0, 1'b1, 1'b0);
        check(wdt_running, 1'b0);
        c = wdt_count;
        repeat (20) @(posedge clk);
        check(wdt_count, c);
        cpu.instr(1'b0, 1'b0, 1'b1);
        check(reset_output_pin, 1'b1);
        check(init_done, 1'b1);
        do_reset();
        cpu.instr(1'b0, 1'b0, 1'b1);
        cpu.instr(1'b0, 1'b1, 1'b0);
        check(wdt_running, 1'b1);
        $display("test disable window done");
        final_report();
    end
endmodule
